// ### logic/dwm_top.sv
// Warning monitor of a closed-loop stepping drive.
// Functional notes
// RULE1: Warning output is asserted whenever any warning condition is detected.
// RULE2: Warnings never stop the motor; drive enable ignores them.
// RULE3: Warning output drops by itself once its cause is gone; the resolution select warning stays until current is turned off.
// RULE4: Currently active warnings are readable by the setting tool.
// RULE5: Log keeps ten most recent codes, newest first, readable and erasable.
// RULE6: Log is emptied when power is removed.
// RULE7: Code 10 when energised deviation exceeds the energised limit.
// RULE8: Code 12 when de-energised deviation exceeds limit, only with auto-return.
// RULE9: Deviation clear input zeroes the accumulated position deviation.
// RULE10: Code 21 when internal temperature exceeds overheat level.
// RULE11: Code 22 when supply voltage exceeds overvoltage level.
// RULE12: Code 25 when supply voltage falls below undervoltage level.
// RULE13: Code 30 when overtorque lasts at least the overload warning time.
// RULE14: Code 31 when motor speed exceeds overspeed level.
// RULE15: Warning if resolution select changes while energised; host holds it.
// RULE16: Code 70 when travel from home exceeds 2,147,483,648 pulses, if enabled.
// RULE17: Position preset makes present position the new home.
// RULE18: Code 71 when gear-derived resolution is outside 100 to 10000.
// RULE19: Warning output is the OR of all conditions.
`timescale 1ns/100ps
module dwm_top
   import dwm_pkg::*;
#(
   parameter int OVL_TICK = OVL_TICK_CYC,
   parameter int LEVEL_W = 16
) (
   input wire logic CLK_I,
   input wire logic RST_N_I,
   input wire logic CMD_STEP_I,
   input wire logic CMD_DIR_I,
   input wire logic ENC_STEP_I,
   input wire logic ENC_DIR_I,
   input wire logic CURRENT_ON_I,
   input wire logic DEV_CLEAR_I,
   input wire logic POS_PRESET_I,
   input wire logic RES_SEL_I,
   input wire logic [LEVEL_W-1:0] TEMP_I,
   input wire logic [LEVEL_W-1:0] VBUS_I,
   input wire logic OVERTORQUE_I,
   input wire logic [LEVEL_W-1:0] SPEED_I,
   input wire logic [15:0] GEAR_NUM_I,
   input wire logic [15:0] GEAR_DEN_I,
   input wire logic [31:0] ENER_DEV_LIMIT_I,
   input wire logic [31:0] DEENER_DEV_LIMIT_I,
   input wire logic AUTO_RETURN_EN_I,
   input wire logic [LEVEL_W-1:0] OVERHEAT_WARN_LEVEL_I,
   input wire logic [LEVEL_W-1:0] OVERVOLT_WARN_LEVEL_I,
   input wire logic [LEVEL_W-1:0] UNDERVOLT_WARN_LEVEL_I,
   input wire logic [15:0] OVERLOAD_WARN_TIME_I,
   input wire logic [LEVEL_W-1:0] OVERSPEED_WARN_LEVEL_I,
   input wire logic RANGE_WARN_EN_I,
   input wire logic LOG_CLEAR_I,
   input wire logic [LOG_IDX_W-1:0] LOG_RD_IDX_I,
   output logic WARNING_OUTPUT_O,
   output logic [WARN_N-1:0] ACTIVE_WARN_O,
   output logic DRIVE_EN_O,
   output logic [CODE_W-1:0] LOG_RD_CODE_O,
   output logic [LOG_IDX_W-1:0] LOG_COUNT_O,
   output logic signed [POS_W-1:0] DEVIATION_O,
   output logic signed [POS_W-1:0] TRAVEL_O
);
   typedef struct packed {
      logic clr_s1;
      logic clr_s2;
      logic pre_s1;
      logic pre_s2;
      logic rs_s1;
      logic rs_s2;
      logic rs_s3;
      logic [1:0] rs_fill;
      logic signed [POS_W-1:0] dev;
      logic signed [POS_W-1:0] trav;
      logic rs_warn;
      logic [WARN_N-1:0] warn;
      logic [WARN_N-1:0] logged;
      logic out;
      logic push;
      logic [CODE_W-1:0] push_code;
      logic drive_en;
   } dwm_top_st_t;

   dwm_top_st_t r;
   dwm_top_st_t n;

   logic ovl_warn;
   logic signed [POS_W-1:0] step_cmd;
   logic signed [POS_W-1:0] step_enc;
   logic [POS_W-1:0] dev_mag;
   logic [POS_W-1:0] trav_mag;
   logic [31:0] gear_prod;
   logic [31:0] gear_lo;
   logic [31:0] gear_hi;
   logic [WARN_N-1:0] cond;
   logic [WARN_N-1:0] pend;
   int pick;

   function automatic logic [POS_W-1:0] mag(input logic signed [POS_W-1:0] v);
      logic [POS_W-1:0] m;
      m = v[POS_W-1] ? POS_W'(-v) : POS_W'(v);
      return m;
   endfunction

   function automatic logic signed [POS_W-1:0] step(input logic en, input logic dir);
      logic signed [POS_W-1:0] s;
      s = '0;
      if (en) begin
         s = dir ? POS_W'(1) : -POS_W'(1);
      end
      return s;
   endfunction

   dwm_ovl_timer #(
      .TICK_CYC(OVL_TICK)
   ) u_ovl (
      .clk_i(CLK_I),
      .rst_n_i(RST_N_I),
      .overtorque_i(OVERTORQUE_I),
      .limit_ms_i(OVERLOAD_WARN_TIME_I),
      .warn_o(ovl_warn)
   );

   always_comb begin
      n = r;
      cond = WARN_NONE;
      pick = -1;
      step_cmd = step(CMD_STEP_I, CMD_DIR_I);
      step_enc = step(ENC_STEP_I, ENC_DIR_I);

      // Clear, preset and resolution select pins pass two flip-flops before use.
      n.clr_s1 = DEV_CLEAR_I;
      n.clr_s2 = r.clr_s1;
      n.pre_s1 = POS_PRESET_I;
      n.pre_s2 = r.pre_s1;
      n.rs_s1 = RES_SEL_I;
      n.rs_s2 = r.rs_s1;
      n.rs_s3 = r.rs_s2;

      if (r.clr_s2) begin
         n.dev = POS_ZERO; // RULE9
      end else begin
         n.dev = r.dev + step_cmd - step_enc;
      end

      if (r.pre_s2) begin
         n.trav = POS_ZERO; // RULE17
      end else begin
         n.trav = r.trav + step_enc;
      end

      // Sync stages leave reset at zero, so a high pin would look like a change.
      // A change is trusted only once all three stages hold real pin samples.
      if (r.rs_fill != 2'h3) begin
         n.rs_fill = r.rs_fill + 2'h1;
      end

      // Resolution select is latched as changed until the current is turned off.
      if (!CURRENT_ON_I) begin
         n.rs_warn = 1'b0;
      end else if ((r.rs_fill == 2'h3) && (r.rs_s2 != r.rs_s3)) begin
         n.rs_warn = 1'b1; // RULE15
      end

      dev_mag = mag(r.dev);
      trav_mag = mag(r.trav);
      gear_prod = GEAR_BASE_RES * {16'h0000, GEAR_DEN_I};
      gear_lo = RES_MIN * {16'h0000, GEAR_NUM_I};
      gear_hi = RES_MAX * {16'h0000, GEAR_NUM_I};

      cond[W_DEV_ON] = CURRENT_ON_I && (dev_mag > {2'b00, ENER_DEV_LIMIT_I}); // RULE7
      cond[W_DEV_OFF] = !CURRENT_ON_I && AUTO_RETURN_EN_I
         && (dev_mag > {2'b00, DEENER_DEV_LIMIT_I}); // RULE8
      cond[W_HEAT] = TEMP_I > OVERHEAT_WARN_LEVEL_I; // RULE10
      cond[W_OVOLT] = VBUS_I > OVERVOLT_WARN_LEVEL_I; // RULE11
      cond[W_UVOLT] = VBUS_I < UNDERVOLT_WARN_LEVEL_I; // RULE12
      cond[W_OVLD] = ovl_warn; // RULE13
      cond[W_OSPD] = SPEED_I > OVERSPEED_WARN_LEVEL_I; // RULE14
      cond[W_RESSEL] = r.rs_warn; // RULE15
      cond[W_RANGE] = RANGE_WARN_EN_I && (trav_mag > RANGE_LIMIT); // RULE16
      cond[W_GEAR] = (GEAR_NUM_I == 16'h0000) || (gear_prod < gear_lo)
         || (gear_prod > gear_hi); // RULE18

      // Conditions are levels, so each warning except the latched resolution select one clears as soon as its cause goes.
      n.warn = cond; // RULE3 RULE4
      n.out = |cond; // RULE1 RULE19

      // One new warning per cycle enters the log, lowest index first.
      pend = r.warn & ~r.logged;
      for (int i = WARN_N - 1; i >= 0; i--) begin
         if (pend[i]) begin
            pick = i;
         end
      end
      n.logged = r.logged & r.warn;
      n.push = 1'b0;
      n.push_code = CODE_NONE;
      if (pick >= 0) begin
         n.logged[pick] = 1'b1;
         n.push = 1'b1; // RULE5
         n.push_code = dwm_code_of(pick);
      end

      // Drive enable follows the current command only; warnings never gate it.
      n.drive_en = CURRENT_ON_I; // RULE2
   end

   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   dwm_log #(
      .DEPTH(LOG_DEPTH)
   ) u_log (
      .clk_i(CLK_I),
      .rst_n_i(RST_N_I), // RULE6
      .push_i(r.push),
      .code_i(r.push_code),
      .clear_i(LOG_CLEAR_I), // RULE5
      .rd_idx_i(LOG_RD_IDX_I),
      .rd_code_o(LOG_RD_CODE_O),
      .count_o(LOG_COUNT_O)
   );

   assign WARNING_OUTPUT_O = r.out;
   assign ACTIVE_WARN_O = r.warn;
   assign DRIVE_EN_O = r.drive_en;
   assign DEVIATION_O = r.dev;
   assign TRAVEL_O = r.trav;
endmodule

// ### logic/dwm_pkg.sv
// Constants, warning codes and helpers shared by the drive warning monitor.
package dwm_pkg;
   localparam int CLK_FREQ_HZ = 40_000_000;
   localparam int OVL_TICK_US = 1000;
   localparam int OVL_TICK_CYC = (CLK_FREQ_HZ / 1_000_000) * OVL_TICK_US;

   localparam int WARN_N = 10;
   localparam int W_DEV_ON = 0;
   localparam int W_DEV_OFF = 1;
   localparam int W_HEAT = 2;
   localparam int W_OVOLT = 3;
   localparam int W_UVOLT = 4;
   localparam int W_OVLD = 5;
   localparam int W_OSPD = 6;
   localparam int W_RESSEL = 7;
   localparam int W_RANGE = 8;
   localparam int W_GEAR = 9;

   localparam logic [7:0] CODE_DEV_ON = 8'h0A;
   localparam logic [7:0] CODE_DEV_OFF = 8'h0C;
   localparam logic [7:0] CODE_HEAT = 8'h15;
   localparam logic [7:0] CODE_OVOLT = 8'h16;
   localparam logic [7:0] CODE_UVOLT = 8'h19;
   localparam logic [7:0] CODE_OVLD = 8'h1E;
   localparam logic [7:0] CODE_OSPD = 8'h1F;
   localparam logic [7:0] CODE_RESSEL = 8'h20;
   localparam logic [7:0] CODE_RANGE = 8'h46;
   localparam logic [7:0] CODE_GEAR = 8'h47;
   localparam logic [7:0] CODE_NONE = 8'h00;

   localparam int LOG_DEPTH = 10;
   localparam int LOG_IDX_W = 4;
   localparam int CODE_W = 8;

   localparam int POS_W = 34;
   localparam logic [POS_W-1:0] RANGE_LIMIT = 34'h080000000;
   localparam logic [31:0] GEAR_BASE_RES = 32'h000003E8;
   localparam logic [31:0] RES_MIN = 32'h00000064;
   localparam logic [31:0] RES_MAX = 32'h00002710;

   localparam logic [POS_W-1:0] POS_ZERO = 34'h000000000;
   localparam logic [WARN_N-1:0] WARN_NONE = 10'h000;

   function automatic logic [7:0] dwm_code_of(input int idx);
      logic [7:0] c;
      c = CODE_NONE;
      case (idx)
         W_DEV_ON: c = CODE_DEV_ON;
         W_DEV_OFF: c = CODE_DEV_OFF;
         W_HEAT: c = CODE_HEAT;
         W_OVOLT: c = CODE_OVOLT;
         W_UVOLT: c = CODE_UVOLT;
         W_OVLD: c = CODE_OVLD;
         W_OSPD: c = CODE_OSPD;
         W_RESSEL: c = CODE_RESSEL;
         W_RANGE: c = CODE_RANGE;
         W_GEAR: c = CODE_GEAR;
         default: c = CODE_NONE;
      endcase
      return c;
   endfunction
endpackage

// ### logic/dwm_log.sv
// Ten-entry recent warning log, newest entry at index zero.
`timescale 1ns/100ps
module dwm_log
   import dwm_pkg::*;
#(
   parameter int DEPTH = LOG_DEPTH
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic push_i,
   input wire logic [CODE_W-1:0] code_i,
   input wire logic clear_i,
   input wire logic [LOG_IDX_W-1:0] rd_idx_i,
   output logic [CODE_W-1:0] rd_code_o,
   output logic [LOG_IDX_W-1:0] count_o
);
   typedef struct packed {
      logic [DEPTH-1:0][CODE_W-1:0] ent;
      logic [LOG_IDX_W-1:0] cnt;
      logic [CODE_W-1:0] rd;
   } dwm_log_st_t;

   dwm_log_st_t r;
   dwm_log_st_t n;

   always_comb begin
      n = r;
      if (clear_i) begin
         n.ent = '0;
         n.cnt = '0;
      end
      // A push in the clearing cycle survives as the only entry.
      if (push_i) begin
         for (int i = DEPTH - 1; i > 0; i--) begin
            n.ent[i] = n.ent[i-1];
         end
         n.ent[0] = code_i;
         if (n.cnt < LOG_IDX_W'(DEPTH)) begin
            n.cnt = n.cnt + 1'b1;
         end
      end
      if (rd_idx_i < r.cnt) begin
         n.rd = r.ent[rd_idx_i];
      end else begin
         n.rd = CODE_NONE;
      end
   end

   // Power-on reset is the only reset, so losing power empties the log.
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   assign rd_code_o = r.rd;
   assign count_o = r.cnt;
endmodule

// ### logic/dwm_ovl_timer.sv
// Measures how long the load has stayed above maximum torque.
`timescale 1ns/100ps
module dwm_ovl_timer
   import dwm_pkg::*;
#(
   parameter int TICK_CYC = OVL_TICK_CYC
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic overtorque_i,
   input wire logic [15:0] limit_ms_i,
   output logic warn_o
);
   typedef struct packed {
      logic [31:0] pre;
      logic [15:0] dur;
      logic warn;
   } dwm_ovl_st_t;

   dwm_ovl_st_t r;
   dwm_ovl_st_t n;

   always_comb begin
      n = r;
      if (!overtorque_i) begin
         n.pre = '0;
         n.dur = '0;
      end else if (r.pre == 32'(TICK_CYC - 1)) begin
         n.pre = '0;
         if (r.dur != 16'hFFFF) begin
            n.dur = r.dur + 16'h0001;
         end
      end else begin
         n.pre = r.pre + 32'h00000001;
      end
      n.warn = overtorque_i && (n.dur >= limit_ms_i);
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   assign warn_o = r.warn;
endmodule

// ### dv/dwm_chk.sv
// Port-level assertions of the drive warning monitor.
`timescale 1ns/100ps
module dwm_chk
   import dwm_pkg::*;
#(
   parameter int LEVEL_W = 16
) (
   input wire logic CLK_I,
   input wire logic RST_N_I,
   input wire logic CURRENT_ON_I,
   input wire logic RES_SEL_I,
   input wire logic [LEVEL_W-1:0] TEMP_I,
   input wire logic [15:0] GEAR_NUM_I,
   input wire logic [15:0] GEAR_DEN_I,
   input wire logic [31:0] ENER_DEV_LIMIT_I,
   input wire logic [31:0] DEENER_DEV_LIMIT_I,
   input wire logic AUTO_RETURN_EN_I,
   input wire logic [LEVEL_W-1:0] OVERHEAT_WARN_LEVEL_I,
   input wire logic LOG_CLEAR_I,
   input wire logic WARNING_OUTPUT_O,
   input wire logic [WARN_N-1:0] ACTIVE_WARN_O,
   input wire logic DRIVE_EN_O,
   input wire logic [LOG_IDX_W-1:0] LOG_COUNT_O,
   input wire logic signed [POS_W-1:0] DEVIATION_O,
   input wire logic RANGE_WARN_EN_I,
   input wire logic signed [POS_W-1:0] TRAVEL_O
);
   logic [POS_W-1:0] dev_abs;
   logic [POS_W-1:0] trav_abs;
   logic [31:0] prod;
   logic [31:0] res;
   logic heat_c, gear_c, don_c, doff_c, rng_c;
   assign dev_abs = DEVIATION_O[POS_W-1] ? -DEVIATION_O : DEVIATION_O;
   assign trav_abs = TRAVEL_O[POS_W-1] ? -TRAVEL_O : TRAVEL_O;
   assign prod = GEAR_BASE_RES * {16'h0000, GEAR_DEN_I};
   assign res = prod / {16'h0000, GEAR_NUM_I};
   // A resolution a fraction above the top limit lies outside the range as well.
   assign gear_c = (GEAR_NUM_I == 16'h0000) || (res < RES_MIN) || (res > RES_MAX)
      || ((res == RES_MAX) && (prod != res * {16'h0000, GEAR_NUM_I}));
   assign rng_c = RANGE_WARN_EN_I && (trav_abs > RANGE_LIMIT);
   assign heat_c = TEMP_I > OVERHEAT_WARN_LEVEL_I;
   assign don_c = CURRENT_ON_I && (dev_abs > {2'h0, ENER_DEV_LIMIT_I});
   assign doff_c = !CURRENT_ON_I && AUTO_RETURN_EN_I && (dev_abs > {2'h0, DEENER_DEV_LIMIT_I});
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (!RST_N_I);
   sequence ressel_chg;
      CURRENT_ON_I && $changed(RES_SEL_I);
   endsequence
   sequence held_on;
      CURRENT_ON_I [*4];
   endsequence
   chk_warn_or: assert property (WARNING_OUTPUT_O == |ACTIVE_WARN_O)
      else $error("warning output is not the OR of warnings");
   chk_drive_free: assert property ($past(RST_N_I) |-> DRIVE_EN_O == $past(CURRENT_ON_I))
      else $error("drive enable does not follow current on");
   chk_heat_warn: assert property ($past(RST_N_I) |->
      ACTIVE_WARN_O[W_HEAT] == $past(heat_c))
      else $error("overheat warning wrong");
   chk_gear_warn: assert property ($past(RST_N_I) |->
      ACTIVE_WARN_O[W_GEAR] == $past(gear_c))
      else $error("gear warning wrong");
   chk_dev_on: assert property ($past(RST_N_I) |->
      ACTIVE_WARN_O[W_DEV_ON] == $past(don_c))
      else $error("energised deviation warning wrong");
   chk_dev_off: assert property ($past(RST_N_I) |->
      ACTIVE_WARN_O[W_DEV_OFF] == $past(doff_c))
      else $error("de-energised deviation warning wrong");
   chk_ressel_warn: assert property (ressel_chg ##1 held_on |-> ACTIVE_WARN_O[W_RESSEL])
      else $error("resolution select warning missing");
   chk_log_clear: assert property (LOG_CLEAR_I |=> LOG_COUNT_O <= 4'h1)
      else $error("log not emptied by clear");
   chk_range_warn: assert property ($past(RST_N_I) |->
      ACTIVE_WARN_O[W_RANGE] == $past(rng_c))
      else $error("travel range warning wrong");
endmodule
bind dwm_top dwm_chk #(.LEVEL_W(LEVEL_W)) u_chk (.CLK_I, .RST_N_I, .CURRENT_ON_I, .RES_SEL_I,
   .TEMP_I, .GEAR_NUM_I, .GEAR_DEN_I, .ENER_DEV_LIMIT_I, .DEENER_DEV_LIMIT_I,
   .AUTO_RETURN_EN_I, .OVERHEAT_WARN_LEVEL_I, .LOG_CLEAR_I, .WARNING_OUTPUT_O,
   .ACTIVE_WARN_O, .DRIVE_EN_O, .LOG_COUNT_O, .DEVIATION_O, .RANGE_WARN_EN_I, .TRAVEL_O);

// ### dv/dwm_host.sv
// Host controller model issuing bursts of step pulses.
`timescale 1ns/100ps
module dwm_host (
   input wire logic clk_i,
   input wire logic go_i,
   input wire logic dir_i,
   input wire logic [7:0] cnt_i,
   output logic step_o,
   output logic dir_o
);
   logic [7:0] left_r = 8'h00;
   always @(posedge clk_i) begin
      if (go_i) begin
         left_r <= cnt_i;
      end else if (left_r != 8'h00) begin
         left_r <= left_r - 8'h01;
      end
   end
   // Direction means nothing without a step, so it shows the inverse when idle.
   assign step_o = left_r != 8'h00;
   assign dir_o = step_o ? dir_i : ~dir_i;
endmodule

// ### dv/dwm_top_tb.sv
// Self-checking bench of the drive warning monitor.
`timescale 1ns/100ps
module dwm_top_tb;
   import dwm_pkg::*;
   logic CLK_I = 1'b0, RST_N_I = 1'b0, CMD_STEP_I, CMD_DIR_I, ENC_STEP_I, ENC_DIR_I;
   logic CURRENT_ON_I = 1'b0, DEV_CLEAR_I = 1'b0, POS_PRESET_I = 1'b0, RES_SEL_I = 1'b0;
   logic OVERTORQUE_I = 1'b0, AUTO_RETURN_EN_I = 1'b0, RANGE_WARN_EN_I = 1'b0;
   logic LOG_CLEAR_I = 1'b0, WARNING_OUTPUT_O, DRIVE_EN_O, cgo = 1'b0, ego = 1'b0, ddir = 1'b1;
   logic [15:0] TEMP_I = 16'h0400, VBUS_I = 16'h0600, SPEED_I = 16'h0000;
   logic [15:0] GEAR_NUM_I = 16'h03E8, GEAR_DEN_I = 16'h03E8, OVERLOAD_WARN_TIME_I = 16'h0003;
   logic [15:0] OVERHEAT_WARN_LEVEL_I = 16'h0800, OVERVOLT_WARN_LEVEL_I = 16'h0900;
   logic [15:0] UNDERVOLT_WARN_LEVEL_I = 16'h0300, OVERSPEED_WARN_LEVEL_I = 16'h1000;
   logic [31:0] ENER_DEV_LIMIT_I = 32'h00000005, DEENER_DEV_LIMIT_I = 32'h00000003;
   logic [3:0] LOG_RD_IDX_I = 4'h0, LOG_COUNT_O;
   logic [7:0] LOG_RD_CODE_O, n = 8'h00;
   logic [9:0] ACTIVE_WARN_O;
   logic [5:0] gerr = 6'h13;
   logic signed [33:0] DEVIATION_O, TRAVEL_O;
   logic [31:0] gtab [6] = '{32'h000003E8, 32'h03E80063, 32'h03E80064, 32'h006403E8,
      32'h006303E8, 32'h03E803E8};
   logic [7:0] ctab [4] = '{CODE_OSPD, CODE_OVOLT, CODE_HEAT, CODE_HEAT};
   int miscompares = 0, total_checks = 0;
   always #12.5 CLK_I = ~CLK_I;
   dwm_top #(.OVL_TICK(4)) DUT (.CLK_I, .RST_N_I, .CMD_STEP_I, .CMD_DIR_I, .ENC_STEP_I,
      .ENC_DIR_I, .CURRENT_ON_I, .DEV_CLEAR_I, .POS_PRESET_I, .RES_SEL_I, .TEMP_I, .VBUS_I,
      .OVERTORQUE_I, .SPEED_I, .GEAR_NUM_I, .GEAR_DEN_I, .ENER_DEV_LIMIT_I,
      .DEENER_DEV_LIMIT_I, .AUTO_RETURN_EN_I, .OVERHEAT_WARN_LEVEL_I, .OVERVOLT_WARN_LEVEL_I,
      .UNDERVOLT_WARN_LEVEL_I, .OVERLOAD_WARN_TIME_I, .OVERSPEED_WARN_LEVEL_I,
      .RANGE_WARN_EN_I, .LOG_CLEAR_I, .LOG_RD_IDX_I, .WARNING_OUTPUT_O, .ACTIVE_WARN_O,
      .DRIVE_EN_O, .LOG_RD_CODE_O, .LOG_COUNT_O, .DEVIATION_O, .TRAVEL_O);
   dwm_host u_cmd (.clk_i(CLK_I), .go_i(cgo), .dir_i(ddir), .cnt_i(n), .step_o(CMD_STEP_I),
      .dir_o(CMD_DIR_I));
   dwm_host u_enc (.clk_i(CLK_I), .go_i(ego), .dir_i(ddir), .cnt_i(n), .step_o(ENC_STEP_I),
      .dir_o(ENC_DIR_I));
   task automatic cyc(input int k);
      repeat (k) @(negedge CLK_I);
   endtask
   task automatic cmp_w(input logic [9:0] e);
      total_checks++;
      if (ACTIVE_WARN_O !== e || WARNING_OUTPUT_O !== |e) begin
         miscompares++;
         $display("MISMATCH %0t warnings %h expected %h", $time, ACTIVE_WARN_O, e);
      end
   endtask
   task automatic cmp_v(input logic [33:0] g, input logic [33:0] e);
      total_checks++;
      if (g !== e) begin
         miscompares++;
         $display("MISMATCH %0t value %h expected %h", $time, g, e);
      end
   endtask
   task automatic step(input logic c, input logic [7:0] k);
      n = k;
      cgo = c;
      ego = !c;
      cyc(1);
      cgo = 1'b0;
      ego = 1'b0;
      cyc(k + 4);
   endtask
   function automatic logic [9:0] meas();
      logic [9:0] w;
      w = WARN_NONE;
      w[W_HEAT] = TEMP_I > OVERHEAT_WARN_LEVEL_I;
      w[W_OVOLT] = VBUS_I > OVERVOLT_WARN_LEVEL_I;
      w[W_UVOLT] = VBUS_I < UNDERVOLT_WARN_LEVEL_I;
      w[W_OSPD] = SPEED_I > OVERSPEED_WARN_LEVEL_I;
      return w;
   endfunction
   task automatic finish_test;
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   initial begin
      void'($urandom(32'hB489));
      cyc(2);
      RST_N_I = 1'b1;
      cyc(2);
      cmp_w(WARN_NONE);
      cmp_v(34'(LOG_COUNT_O), 34'h0);
      for (int i = 0; i < 40; i++) begin
         TEMP_I = (i == 0) ? 16'h0800 : 16'(16'h0700 + $urandom_range(0, 512));
         VBUS_I = (i == 1) ? 16'h0300 : 16'(16'h0200 + $urandom_range(0, 2048));
         SPEED_I = (i == 2) ? 16'h1000 : 16'(16'h0F00 + $urandom_range(0, 512));
         CURRENT_ON_I = 1'($urandom);
         cyc(2);
         cmp_w(meas());
         cmp_v(34'(DRIVE_EN_O), 34'(CURRENT_ON_I));
      end
      TEMP_I = 16'h0400;
      VBUS_I = 16'h0600;
      SPEED_I = 16'h0000;
      CURRENT_ON_I = 1'b1;
      cyc(3);
      LOG_CLEAR_I = 1'b1;
      cyc(1);
      LOG_CLEAR_I = 1'b0;
      cyc(2);
      cmp_v(34'(LOG_COUNT_O), 34'h0);
      for (int i = 0; i < 12; i++) begin
         TEMP_I = 16'hFFFF;
         cyc(3);
         TEMP_I = 16'h0400;
         cyc(3);
      end
      VBUS_I = 16'hFFFF;
      cyc(3);
      VBUS_I = 16'h0600;
      SPEED_I = 16'hFFFF;
      cyc(3);
      SPEED_I = 16'h0000;
      cyc(3);
      cmp_v(34'(LOG_COUNT_O), 34'(LOG_DEPTH));
      for (int i = 0; i < 5; i++) begin
         LOG_RD_IDX_I = (i == 4) ? 4'hA : 4'(i);
         cyc(2);
         cmp_v(34'(LOG_RD_CODE_O), (i == 4) ? 34'h0 : 34'(ctab[i]));
      end
      step(1'b1, 8'h05);
      cmp_v(DEVIATION_O, 34'h5);
      cmp_w(WARN_NONE);
      step(1'b1, 8'h01);
      cmp_w(10'h001 << W_DEV_ON);
      step(1'b0, 8'h01);
      cmp_w(WARN_NONE);
      CURRENT_ON_I = 1'b0;
      cyc(3);
      cmp_w(WARN_NONE);
      AUTO_RETURN_EN_I = 1'b1;
      cyc(3);
      cmp_w(10'h001 << W_DEV_OFF);
      DEV_CLEAR_I = 1'b1;
      cyc(5);
      DEV_CLEAR_I = 1'b0;
      cyc(2);
      cmp_v(DEVIATION_O, 34'h0);
      cmp_w(WARN_NONE);
      OVERTORQUE_I = 1'b1;
      cyc(8);
      cmp_w(WARN_NONE);
      cyc(12);
      cmp_w(10'h001 << W_OVLD);
      OVERTORQUE_I = 1'b0;
      cyc(4);
      cmp_w(WARN_NONE);
      for (int i = 0; i < 6; i++) begin
         {GEAR_NUM_I, GEAR_DEN_I} = gtab[i];
         cyc(2);
         cmp_w(gerr[i] ? 10'h200 : WARN_NONE);
      end
      CURRENT_ON_I = 1'b1;
      RES_SEL_I = 1'b1;
      cyc(6);
      cmp_w(10'h001 << W_RESSEL);
      CURRENT_ON_I = 1'b0;
      cyc(3);
      cmp_w(WARN_NONE);
      CURRENT_ON_I = 1'b1;
      ddir = 1'b0;
      step(1'b1, 8'h06);
      cmp_v(DEVIATION_O, 34'h3FFFFFFFA);
      cmp_w(10'h001 << W_DEV_ON);
      step(1'b0, 8'h06);
      cmp_v(TRAVEL_O, 34'h3FFFFFFFB);
      cmp_w(WARN_NONE);
      ddir = 1'b1;
      CURRENT_ON_I = 1'b0;
      AUTO_RETURN_EN_I = 1'b0;
      RANGE_WARN_EN_I = 1'b1;
      step(1'b1, 8'h14);
      POS_PRESET_I = 1'b1;
      cyc(5);
      POS_PRESET_I = 1'b0;
      cyc(2);
      cmp_v(TRAVEL_O, 34'h0);
      cmp_w(WARN_NONE);
      RST_N_I = 1'b0;
      CURRENT_ON_I = 1'b1;
      cyc(2);
      RST_N_I = 1'b1;
      cyc(2);
      cmp_v(34'(LOG_COUNT_O), 34'h0);
      cyc(4);
      cmp_w(WARN_NONE);
      finish_test();
   end
endmodule
